// [verilog/swr_regs.svh]
// Behaviour
// - alarm low after full kick-free timeout
// - either kick edge clears watchdog counter
// - counter held cleared while reset asserted
// - floating kick input disables the watchdog
// - disabled watchdog: alarm is low-line flag
// - timeout alarm stays low until cleared
// - supply low forces alarm low
// - supply recovery releases alarm at once
// - reset held while supply low
// - reset stretched after supply or manual release
// - manual reset low asserts reset
// - timeout alone never asserts reset
// - active-high reset is complement of reset
// - manual input debounced by stretch period
`ifndef SWR_REGS_SVH
`define SWR_REGS_SVH
`define SWR_CLK_HZ          40000000
`define SWR_WD_TIMEOUT_MS   1600
`define SWR_STRETCH_MS      200
`define SWR_WD_CYCLES  ((`SWR_CLK_HZ / 1000) * `SWR_WD_TIMEOUT_MS)
`define SWR_ST_CYCLES  ((`SWR_CLK_HZ / 1000) * `SWR_STRETCH_MS)
`define SWR_CNT_W           32
`endif

// [verilog/swr_pkg.sv]
package swr_pkg;
    typedef enum logic [1:0] {
        SWR_RST_HOLD,
        SWR_RST_STRETCH,
        SWR_RST_RUN
    } swr_rst_state_t;
endpackage : swr_pkg

// [verilog/swr_sync.sv]
`timescale 1ns/1ps
`default_nettype none
// three-stage synchroniser; a change counts when stages two and three agree
module swr_sync (
    input  wire logic clk_in,
    input  wire logic rst_in,
    input  wire logic ce_in,
    input  wire logic init_in,
    input  wire logic d_in,
    output logic      q_out
);
    logic [2:0] stage;
    logic [2:0] next_stage;
    logic       next_q;

    always_comb begin
        next_stage = {stage[1:0], d_in};
        next_q     = (stage[1] == stage[2]) ? stage[2] : q_out;
    end

    // reset value fixed at zero for every instance; the init_in tie is not used
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            stage <= 3'h0;
            q_out <= 1'h0;
        end else if (ce_in) begin
            stage <= next_stage;
            q_out <= next_q;
        end
    end
endmodule : swr_sync
`default_nettype wire

// [verilog/swr_supervisor.sv]
`timescale 1ns/1ps
`default_nettype none
`include "swr_regs.svh"
module swr_supervisor #(
    parameter logic [31:0] WD_CYCLES = 32'(`SWR_WD_CYCLES),
    parameter logic [31:0] ST_CYCLES = 32'(`SWR_ST_CYCLES)
) (
    input  wire logic clk_in,
    input  wire logic rst_in,
    input  wire logic ce_in,
    input  wire logic supply_low_in,
    input  wire logic kick_float_in,
    input  wire logic watchdog_kick_in,
    input  wire logic manual_reset_n_in,
    output logic      reset_n_out,
    output logic      reset_out,
    output logic      watchdog_alarm_n_out
);
    logic                  supply_low;
    logic                  kick_float;
    logic                  kick;
    logic                  mr_low;
    logic                  kick_prev;
    swr_pkg::swr_rst_state_t state;
    swr_pkg::swr_rst_state_t next_state;
    logic [`SWR_CNT_W-1:0] st_cnt;
    logic [`SWR_CNT_W-1:0] next_st_cnt;
    logic [`SWR_CNT_W-1:0] wd_cnt;
    logic [`SWR_CNT_W-1:0] next_wd_cnt;
    logic                  timed_out;
    logic                  next_timed_out;
    logic                  next_reset_n;
    logic                  next_alarm_n;
    logic                  next_kick_prev;
    logic                  trigger;
    logic                  kick_edge;
    logic                  mr_raw_low;

    // slot of each pin inside the synchroniser bank
    localparam int PIN_SUPPLY = 0;
    localparam int PIN_FLOAT  = 1;
    localparam int PIN_KICK   = 2;
    localparam int PIN_MANUAL = 3;
    localparam int SWR_PINS   = 4;

    logic [SWR_PINS-1:0]   pin_raw;
    logic [SWR_PINS-1:0]   pin_sync;

    // terminal count test shared by the stretch and the watchdog counters
    function automatic logic expired(
        input logic [`SWR_CNT_W-1:0] cnt,
        input logic [31:0]           limit
    );
        expired = (cnt >= limit - 32'h1);
    endfunction : expired

    assign mr_raw_low          = ~manual_reset_n_in;
    assign pin_raw[PIN_SUPPLY] = supply_low_in;
    assign pin_raw[PIN_FLOAT]  = kick_float_in;
    assign pin_raw[PIN_KICK]   = watchdog_kick_in;
    assign pin_raw[PIN_MANUAL] = mr_raw_low;

    // every level arrives asynchronously, so each one is synchronised;
    // costs four cycles of latency but no metastable value reaches state
    genvar gi;
    generate
        for (gi = 0; gi < SWR_PINS; gi = gi + 1) begin : g_sync
            swr_sync swr_sync_inst (
                .clk_in  (clk_in),
                .rst_in  (rst_in),
                .ce_in   (ce_in),
                .init_in (1'h0),
                .d_in    (pin_raw[gi]),
                .q_out   (pin_sync[gi])
            );
        end
    endgenerate

    assign supply_low = pin_sync[PIN_SUPPLY];
    assign kick_float = pin_sync[PIN_FLOAT];
    assign kick       = pin_sync[PIN_KICK];
    assign mr_low     = pin_sync[PIN_MANUAL];

    // reset sequencer: hold while a trigger stands, then stretch
    always_comb begin
        trigger     = supply_low | mr_low;
        next_state  = state;
        next_st_cnt = st_cnt;
        case (state)
            swr_pkg::SWR_RST_HOLD: begin
                next_st_cnt = '0;
                if (!trigger) begin
                    next_state = swr_pkg::SWR_RST_STRETCH;
                end
            end
            swr_pkg::SWR_RST_STRETCH: begin
                // any bounce restarts the stretch, giving one long pulse
                if (trigger) begin
                    next_state = swr_pkg::SWR_RST_HOLD;
                end else if (expired(st_cnt, ST_CYCLES)) begin
                    next_state = swr_pkg::SWR_RST_RUN;
                end else begin
                    next_st_cnt = st_cnt + 32'h1;
                end
            end
            swr_pkg::SWR_RST_RUN: begin
                if (trigger) begin
                    next_state = swr_pkg::SWR_RST_HOLD;
                end
            end
            default: next_state = swr_pkg::SWR_RST_HOLD;
        endcase
        // watchdog timeout feeds nothing here; only an external wire can
        next_reset_n = (next_state == swr_pkg::SWR_RST_RUN);
    end

    // watchdog timer
    always_comb begin
        next_kick_prev = kick;
        kick_edge      = kick ^ kick_prev;
        next_wd_cnt    = wd_cnt;
        next_timed_out = timed_out;
        if (!reset_n_out || kick_float || kick_edge) begin
            next_wd_cnt    = '0;
            next_timed_out = 1'h0;
        end else if (expired(wd_cnt, WD_CYCLES)) begin
            next_timed_out = 1'h1;
        end else begin
            next_wd_cnt = wd_cnt + 32'h1;
        end
        // supply state passes straight through, no stretch on recovery
        if (supply_low) begin
            next_alarm_n = 1'h0;
        end else if (next_timed_out) begin
            next_alarm_n = 1'h0;
        end else begin
            next_alarm_n = 1'h1;
        end
    end

    // reset sequencer registers
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state       <= swr_pkg::SWR_RST_HOLD;
            st_cnt      <= '0;
            reset_n_out <= 1'h0;
        end else if (ce_in) begin
            state       <= next_state;
            st_cnt      <= next_st_cnt;
            reset_n_out <= next_reset_n;
        end
    end

    // watchdog registers; alarm idles high so a reset shows no alarm
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wd_cnt               <= '0;
            timed_out            <= 1'h0;
            kick_prev            <= 1'h0;
            watchdog_alarm_n_out <= 1'h1;
        end else if (ce_in) begin
            wd_cnt               <= next_wd_cnt;
            timed_out            <= next_timed_out;
            kick_prev            <= next_kick_prev;
            watchdog_alarm_n_out <= next_alarm_n;
        end
    end

    assign reset_out = ~reset_n_out;
endmodule : swr_supervisor
`default_nettype wire

// [dv/swr_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module swr_sva #(parameter int WD_CYCLES = 50) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic supply_low_in,
    input wire logic kick_float_in,
    input wire logic watchdog_kick_in,
    input wire logic manual_reset_n_in,
    input wire logic reset_n_out,
    input wire logic reset_out,
    input wire logic watchdog_alarm_n_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    int quiet;
    // margin of 8 covers sync latency plus the alarm register
    always_ff @(posedge clk_in or posedge rst_in)
        if (rst_in) quiet <= 0;
        else if (!ce_in) quiet <= quiet;
        else if (!reset_n_out || kick_float_in || supply_low_in ||
                 watchdog_kick_in != $past(watchdog_kick_in)) quiet <= 0;
        else if (quiet < 999) quiet <= quiet + 1;
    property p_inv; reset_out == !reset_n_out; endproperty
    property p_srst; supply_low_in [*6] |-> !reset_n_out; endproperty
    property p_salm; supply_low_in [*6] |-> !watchdog_alarm_n_out; endproperty
    property p_man; !manual_reset_n_in [*6] |-> !reset_n_out; endproperty
    property p_str; $rose(reset_n_out) |->
        $past(manual_reset_n_in, 20) && !$past(supply_low_in, 20); endproperty
    property p_flt; (kick_float_in && !supply_low_in) [*6] |->
        watchdog_alarm_n_out; endproperty
    property p_tmo; quiet >= WD_CYCLES + 8 |-> !watchdog_alarm_n_out;
    endproperty
    property p_early; quiet > 8 && quiet < WD_CYCLES |->
        watchdog_alarm_n_out; endproperty
    a_inv: assert property (p_inv) else $error("reset_out mismatch");
    a_srst: assert property (p_srst) else $error("no supply reset");
    a_salm: assert property (p_salm) else $error("no supply alarm");
    a_man: assert property (p_man) else $error("no manual reset");
    a_str: assert property (p_str) else $error("short stretch");
    a_flt: assert property (p_flt) else $error("float alarm");
    a_tmo: assert property (p_tmo) else $error("no timeout");
    a_early: assert property (p_early) else $error("early alarm");
    c_rst: cover property ($rose(reset_n_out));
    c_alm: cover property ($fell(watchdog_alarm_n_out));
    c_man: cover property ($fell(manual_reset_n_in));
endmodule : swr_sva
`default_nettype wire

// [dv/swr_host.sv]
`timescale 1ns/1ps
`default_nettype none
module swr_host (
    input  wire logic clk_in,
    input  wire logic run_in,
    output logic      kick_out
);
    int n = 0;
    initial kick_out = 1'b0;
    // toggles every 10 cycles, well inside the timeout
    always @(negedge clk_in) begin
        n = (n + 1) % 10;
        if (run_in && n == 0) kick_out = !kick_out;
    end
endmodule : swr_host
`default_nettype wire

// [dv/supervisor_watchdog_reset_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module supervisor_watchdog_reset_tb;
    logic clk_in = 0, rst_in = 1, sup = 0, flt = 0, mr_n = 1, run = 1;
    logic ce = 1;
    logic kick, rst_n, rst_hi, alm_n;
    int mismatches = 0, tests_run = 0;
    always #12.5 clk_in = !clk_in;
    swr_host swr_host_inst (.clk_in(clk_in), .run_in(run), .kick_out(kick));
    swr_supervisor #(.WD_CYCLES(32'h32), .ST_CYCLES(32'h14))
    swr_supervisor_inst (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce),
        .supply_low_in(sup), .kick_float_in(flt), .watchdog_kick_in(kick),
        .manual_reset_n_in(mr_n), .reset_n_out(rst_n), .reset_out(rst_hi),
        .watchdog_alarm_n_out(alm_n));
    task automatic chk(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t: output mismatch", $time);
        end
    endtask : chk
    task automatic wt(input int n); repeat (n) @(negedge clk_in); endtask : wt
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : give_verdict
    task automatic t_manual(); // bounce then release
        mr_n = 0; wt(3); mr_n = 1; wt(2); mr_n = 0; wt(8);
        chk(rst_n, 1'b0);
        chk(rst_hi, 1'b1);
        mr_n = 1; wt(18);
        chk(rst_n, 1'b0);
        wt(12);
        chk(rst_n, 1'b1);
        $display("done t_manual");
    endtask : t_manual
    task automatic t_tmo();
        run = 0; wt(70);
        chk(alm_n, 1'b0);
        chk(rst_n, 1'b1);
        wt(30);
        chk(alm_n, 1'b0);
        run = 1; wt(15);
        chk(alm_n, 1'b1);
        $display("done t_tmo");
    endtask : t_tmo
    task automatic t_sup();
        sup = 1; wt(8);
        chk(rst_n, 1'b0);
        chk(alm_n, 1'b0);
        sup = 0; wt(6);
        chk(alm_n, 1'b1);
        wt(30);
        chk(rst_n, 1'b1);
        $display("done t_sup");
    endtask : t_sup
    task automatic t_flt();
        flt = 1; run = 0; wt(80);
        chk(alm_n, 1'b1);
        sup = 1; wt(8);
        chk(alm_n, 1'b0);
        sup = 0; wt(40);
        chk(alm_n, 1'b1);
        flt = 0; run = 1;
        $display("done t_flt");
    endtask : t_flt
    task automatic t_ce(); // enable low freezes the timer
        run = 0; wt(20); ce = 0; wt(100);
        chk(alm_n, 1'b1);
        ce = 1; wt(60);
        chk(alm_n, 1'b0);
        run = 1; wt(15);
        chk(alm_n, 1'b1);
        $display("done t_ce");
    endtask : t_ce
    initial begin
        wt(6); rst_in = 0; wt(10);
        chk(rst_n, 1'b0);
        wt(30);
        chk(rst_n, 1'b1);
        t_manual(); t_tmo(); t_sup(); t_flt(); t_ce();
        give_verdict();
    end
    initial begin
        #100000;
        mismatches++;
        give_verdict();
    end
endmodule : supervisor_watchdog_reset_tb
bind swr_supervisor swr_sva #(.WD_CYCLES(WD_CYCLES)) swr_sva_inst (
    .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
    .supply_low_in(supply_low_in),
    .kick_float_in(kick_float_in), .watchdog_kick_in(watchdog_kick_in),
    .manual_reset_n_in(manual_reset_n_in), .reset_n_out(reset_n_out),
    .reset_out(reset_out), .watchdog_alarm_n_out(watchdog_alarm_n_out));
`default_nettype wire
